/* hw/irtx_carrier_div.sv */
// carrier divider: half-period counter and square-wave phase
module irtx_carrier_div
  import irtx_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  arst_n_in,
  input  wire logic                  ce_in,
  input  wire logic                  clr_in,
  output logic      [IRTX_CNT_W-1:0] cnt_out,
  output logic                       phase_out
);

  // ==========================================================================
  // counter restarts at zero on clear, else wraps each half period
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_out <= '0;
    end else if (ce_in) begin
      if (clr_in || cnt_out == IRTX_HALF_LAST) begin
        cnt_out <= '0;
      end else begin
        cnt_out <= cnt_out + 1'b1;
      end
    end
  end

  // phase flips at each wrap; a clear also restarts the wave low
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_out <= 1'b0;
    end else if (ce_in) begin
      if (clr_in) begin
        phase_out <= 1'b0;
      end else if (cnt_out == IRTX_HALF_LAST) begin
        phase_out <= ~phase_out;
      end
    end
  end

endmodule

/* hw/irtx_pkg.sv */
// package of constants and types for the infrared carrier transmitter
// ============================================================================
// Summary of operation
// - low-carrier option sends carrier while data bit is 0; high option while 1.
// - carrier frequency is fixed at build time, not by any register.
// - reset loads data bit 0 for high-carrier option, 1 for low-carrier.
// - control bit 0 holds the transmit data level, writable and readable.
// - writing 0 to control bit 3 clears the carrier counter; bit 3 reads 1.
// - control bit 1 picks push-pull (1, reset) or open-drain (0).
// - an enable bit, off after reset, keeps the pin free of carrier.
// ============================================================================
package irtx_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] IRTX_CTL_ADDR  = 8'h2f;
  localparam int         IRTX_DATA_BIT  = 0;
  localparam int         IRTX_PP_BIT    = 1;
  localparam int         IRTX_EN_BIT    = 2;
  localparam int         IRTX_CLR_BIT   = 3;
  localparam logic       IRTX_PP_RST    = 1'b1;
  localparam logic       IRTX_EN_RST    = 1'b0;

  // ==========================================================================
  // build options and timing
  localparam longint     IRTX_CLK_HZ     = 250_000_000;
  localparam longint     IRTX_CARRIER_HZ = 38_000;
  // half carrier period in clock cycles, rounded down
  localparam int         IRTX_HALF_CYC   = int'(IRTX_CLK_HZ / (2 * IRTX_CARRIER_HZ));
  localparam int         IRTX_CNT_W      = 12;
  localparam logic [IRTX_CNT_W-1:0] IRTX_HALF_LAST = IRTX_CNT_W'(IRTX_HALF_CYC - 1);
  localparam logic       IRTX_LOW_CARRIER = 1'b0;
  localparam logic       IRTX_OUT_ALLOWED = 1'b1;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } irtx_bus_type;

  typedef struct packed {
    logic drive;
    logic oe_n;
  } irtx_pin_type;

endpackage

/* hw/irtx_top.sv */
// infrared carrier transmitter: control register, carrier gating, pin drive
module irtx_top
  import irtx_pkg::*;
#(
  parameter logic LOW_CARRIER = IRTX_LOW_CARRIER,
  parameter logic OUT_ALLOWED = IRTX_OUT_ALLOWED
)
(
  input  wire logic       mclk_in,
  input  wire logic       arst_n_in,
  input  wire logic       ce_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  output logic            ir_drive_out,
  output logic            ir_oe_n_out
);

  // ==========================================================================
  // bus decode
  localparam logic DATA_RST = LOW_CARRIER; // idle level sends no carrier

  irtx_bus_type                  bus;
  irtx_pin_type                  pin;
  irtx_pin_type                  next_pin;
  logic                          data_bit;
  logic                          push_pull;
  logic                          ir_enable;
  logic                          ctl_wr;
  logic                          ctl_rd;
  logic                          cnt_clr;
  logic                          carrier_gate;
  logic         [IRTX_CNT_W-1:0] cnt;
  logic                          phase;
  logic         [7:0]            next_rdata;

  assign bus.wr    = wr_in;
  assign bus.rd    = rd_in;
  assign bus.addr  = addr_in;
  assign bus.wdata = wdata_in;
  assign ctl_wr    = bus.wr && bus.addr == IRTX_CTL_ADDR;
  assign ctl_rd    = bus.rd && bus.addr == IRTX_CTL_ADDR;
  assign cnt_clr   = ctl_wr && !bus.wdata[IRTX_CLR_BIT];

  // ==========================================================================
  // control register
  // data bit resets to the level that keeps the carrier off
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      data_bit <= DATA_RST;
    end else if (ce_in && ctl_wr) begin
      data_bit <= bus.wdata[IRTX_DATA_BIT];
    end
  end

  // drive type, push-pull after reset
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      push_pull <= IRTX_PP_RST;
    end else if (ce_in && ctl_wr) begin
      push_pull <= bus.wdata[IRTX_PP_BIT];
    end
  end

  // enable, off after reset
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ir_enable <= IRTX_EN_RST;
    end else if (ce_in && ctl_wr) begin
      ir_enable <= bus.wdata[IRTX_EN_BIT];
    end
  end

  // read data; clear bit always reads high, unused bits and other addresses read 0
  always_comb begin
    next_rdata = 8'h00;
    if (ctl_rd) begin
      next_rdata[IRTX_DATA_BIT] = data_bit;
      next_rdata[IRTX_PP_BIT]   = push_pull;
      next_rdata[IRTX_EN_BIT]   = ir_enable;
      next_rdata[IRTX_CLR_BIT]  = 1'b1;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 8'h00;
    end else if (ce_in) begin
      rdata_out <= next_rdata;
    end
  end

  // ==========================================================================
  // carrier generation
  irtx_carrier_div u_div (
    .clk_in    (mclk_in),
    .arst_n_in (arst_n_in),
    .ce_in     (ce_in),
    .clr_in    (cnt_clr),
    .cnt_out   (cnt),
    .phase_out (phase)
  );

  // carrier passes only when enabled, allowed by option, and data at the active level
  assign carrier_gate = OUT_ALLOWED && ir_enable && (data_bit == !LOW_CARRIER);

  // ==========================================================================
  // pin drive
  // open-drain only pulls low, so the carrier there is pull-low on the low phase;
  // idle open-drain releases the pin so an external pull-up holds it quiet
  always_comb begin
    next_pin.drive = 1'b0;
    next_pin.oe_n  = !push_pull;
    if (carrier_gate) begin
      if (push_pull) begin
        next_pin.drive = phase;
      end else begin
        next_pin.oe_n  = phase;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin.drive <= 1'b0;
      pin.oe_n  <= 1'b0;
    end else if (ce_in) begin
      pin <= next_pin;
    end
  end

  assign ir_drive_out = pin.drive;
  assign ir_oe_n_out  = pin.oe_n;

  // ==========================================================================
  // assertions
  logic started;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      started <= 1'b0;
    end else if (ce_in && ctl_wr) begin
      started <= 1'b1;
    end
  end

  a_carrier_follows_phase: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ce_in && carrier_gate && push_pull) |=> (ir_drive_out == $past(phase)))
    else $error("carrier missing while data at active level");

  a_wrong_level_quiet: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ce_in && data_bit == LOW_CARRIER) |=> (ir_drive_out == 1'b0 && ir_oe_n_out == !$past(push_pull)))
    else $error("carrier sent at inactive data level");

  a_carrier_half_period: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ce_in && !cnt_clr && cnt == IRTX_HALF_LAST) |=> (phase != $past(phase) && cnt == '0))
    else $error("carrier phase did not flip at half period");

  a_counter_bounded: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    cnt <= IRTX_HALF_LAST)
    else $error("carrier counter beyond half period");

  a_reset_data_idle: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    !started |-> (data_bit == DATA_RST && ir_enable == IRTX_EN_RST && push_pull == IRTX_PP_RST))
    else $error("control register not at reset value");

  a_data_readback: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ce_in && ctl_wr) ##1 (ce_in && ctl_rd) |=> (rdata_out[IRTX_DATA_BIT] == $past(bus.wdata[IRTX_DATA_BIT], 2)))
    else $error("data bit readback mismatch");

  a_clear_reads_one: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ce_in && ctl_rd) |=> (rdata_out[IRTX_CLR_BIT] && rdata_out[7:4] == 4'h0))
    else $error("clear bit did not read high");

  a_clear_restarts: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ce_in && cnt_clr) |=> (cnt == '0 && !phase))
    else $error("counter not cleared by write of zero");

  a_drive_type_set: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ce_in && ctl_wr && !bus.wdata[IRTX_PP_BIT]) |=> (!push_pull ##1 (!ce_in || ir_drive_out == 1'b0)))
    else $error("open-drain drove the pin high");

  a_disabled_quiet: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ce_in && !ir_enable) |=> (ir_drive_out == 1'b0 && ir_oe_n_out == !$past(push_pull)))
    else $error("carrier present while disabled");

  a_count_after_clear: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ce_in && cnt_clr) ##1 (ce_in && !cnt_clr) |=> (cnt == IRTX_CNT_W'(1)))
    else $error("counter did not restart from zero");

  a_rdata_one_cycle: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ce_in && !bus.rd) |=> (rdata_out == 8'h00))
    else $error("read data outside read answer cycle");

  c_carrier_toggle: cover property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (carrier_gate && push_pull) ##1 $rose(ir_drive_out));

  c_counter_clear: cover property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ce_in && cnt_clr && cnt != '0));

  c_open_drain_pull: cover property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (!push_pull && carrier_gate) ##1 $fell(ir_oe_n_out));

  c_frozen: cover property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (!ce_in && carrier_gate));

endmodule

/* test/irtx_emitter.sv */
// infrared emitter model hanging on the transmitter's output pin
module irtx_emitter (
  input  wire logic drive_in,
  input  wire logic oe_n_in,
  output logic      lit_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // pin level: a released pin is pulled up, so open-drain shows high when off
  assign lit_out = oe_n_in ? 1'b1 : drive_in;
endmodule

/* test/irtx_top_test.sv */
// self-checking bench for the infrared carrier transmitter
module irtx_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import irtx_pkg::*;
  logic       mclk_in   = 1'b0;
  logic       arst_n_in = 1'b0;
  logic       wr        = 1'b0;
  logic       rd        = 1'b0;
  logic [7:0] addr      = 8'h00;
  logic [7:0] wdata     = 8'h00;
  logic [7:0] rdata_a, rdata_b, ra, rb;
  logic       drv_a, oen_a, drv_b, oen_b, lit_a, lit_b;
  logic       b_lit     = 1'b0;
  logic       ce        = 1'b1;
  int         num_errors = 0;
  int         checks     = 0;
  int         n, hi, lo;
  // ==========================================================================
  // clock, devices under test (both carrier options) and their emitters
  initial forever #2 mclk_in = ~mclk_in;
  irtx_top i_irtx_top (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .ce_in(ce),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata_a),
    .ir_drive_out(drv_a), .ir_oe_n_out(oen_a));
  irtx_top #(.LOW_CARRIER(1'b1)) i_irtx_top_low (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .ce_in(ce), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata_b), .ir_drive_out(drv_b), .ir_oe_n_out(oen_b));
  irtx_emitter i_irtx_emitter (.drive_in(drv_a), .oe_n_in(oen_a), .lit_out(lit_a));
  irtx_emitter i_irtx_emitter_low (.drive_in(drv_b), .oe_n_in(oen_b), .lit_out(lit_b));
  // sticky flag: any light at all from the low-option device
  always @(negedge mclk_in) if (lit_b === 1'b1) b_lit <= 1'b1;
  // ==========================================================================
  // shared tasks
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge mclk_in);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, sampled mid-cycle
  task automatic rd_reg(logic [7:0] a);
    @(posedge mclk_in);
    rd <= 1'b1; addr <= a;
    @(posedge mclk_in);
    rd <= 1'b0;
    @(negedge mclk_in);
    ra = rdata_a; rb = rdata_b;
  endtask
  // cycles until the emitter shows lvl, giving up at lim
  task automatic edge_wait(logic lvl, int lim, output int cnt);
    cnt = 0;
    while (lit_a !== lvl && cnt < lim) begin
      @(negedge mclk_in);
      cnt++;
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    rd_reg(IRTX_CTL_ADDR);
    chk("ctl reset high option", 16'h000a, ra);
    chk("ctl reset low option", 16'h000b, rb);
    chk("pin idle", 16'h0000, {drv_a, oen_a});
    wr_reg(8'h2e, 8'h07);
    rd_reg(8'h2e);
    chk("unmapped read", 16'h0000, ra);
    rd_reg(IRTX_CTL_ADDR);
    chk("ctl after unmapped write", 16'h000a, ra);
  endtask
  task automatic t_carrier();
    wr_reg(IRTX_CTL_ADDR, 8'h07);
    rd_reg(IRTX_CTL_ADDR);
    chk("ctl readback", 16'h000f, ra);
    edge_wait(1'b1, 2 * IRTX_HALF_CYC + 10, n);
    edge_wait(1'b0, 2 * IRTX_HALF_CYC, hi);
    edge_wait(1'b1, 2 * IRTX_HALF_CYC, lo);
    chk("carrier high time", 16'(IRTX_HALF_CYC), 16'(hi));
    chk("carrier low time", 16'(IRTX_HALF_CYC), 16'(lo));
    chk("low option idle", 16'h0000, 16'(b_lit));
  endtask
  // clear about 100 cycles into a high phase: carrier must drop and rise again a half period later
  task automatic t_clear();
    repeat (100) @(negedge mclk_in);
    wr_reg(IRTX_CTL_ADDR, 8'h07);
    edge_wait(1'b0, 3, n);
    chk("drop after clear", 16'h0001, 16'(n < 3));
    edge_wait(1'b1, 2 * IRTX_HALF_CYC, n);
    chk("rise after clear", 16'h0001, 16'(n >= IRTX_HALF_CYC - 3 && n <= IRTX_HALF_CYC));
  endtask
  // data bit or enable off: no light over a full period
  task automatic t_quiet(logic [7:0] ctl, logic [7:0] exp);
    wr_reg(IRTX_CTL_ADDR, ctl);
    rd_reg(IRTX_CTL_ADDR);
    chk("ctl quiet readback", 16'(exp), ra);
    repeat (3) @(negedge mclk_in);
    edge_wait(1'b1, 2 * IRTX_HALF_CYC + 10, n);
    chk("no carrier", 16'(2 * IRTX_HALF_CYC + 10), 16'(n));
  endtask
  // open-drain: light comes from release to the pull-up, never from driving high
  task automatic t_open_drain();
    wr_reg(IRTX_CTL_ADDR, 8'h05);
    edge_wait(1'b1, 2 * IRTX_HALF_CYC + 10, n);
    chk("open-drain pin", 16'h0001, {drv_a, oen_a});
    edge_wait(1'b0, 2 * IRTX_HALF_CYC + 10, n);
    chk("open-drain pull low", 16'h0000, {drv_a, oen_a});
  endtask
  // clock enable low: strobes are ignored and pin and carrier hold still
  task automatic t_freeze();
    logic [1:0] pin_held;
    @(posedge mclk_in);
    ce <= 1'b0;
    @(negedge mclk_in);
    pin_held = {drv_a, oen_a};
    wr_reg(IRTX_CTL_ADDR, 8'h00);
    repeat (2 * IRTX_HALF_CYC) @(negedge mclk_in);
    chk("frozen pin", 16'(pin_held), 16'({drv_a, oen_a}));
    @(posedge mclk_in);
    ce <= 1'b1;
    rd_reg(IRTX_CTL_ADDR);
    chk("ctl after frozen write", 16'h000d, ra);
  endtask
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (3) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_carrier();
    t_clear();
    t_quiet(8'h06, 8'h0e);
    t_quiet(8'h03, 8'h0b);
    t_open_drain();
    t_freeze();
    finish_test();
  end
  initial begin
    #240_000;
    num_errors++;
    finish_test();
  end
endmodule
